// ===== rtl/eoc_cfg.svh
// register map, field positions and mode codes of the external oscillator control
`ifndef EOC_CFG_SVH
`define EOC_CFG_SVH

`define EOC_CTRL_ADDR     8'hb1
`define EOC_CTRL_RST      8'h00
`define EOC_VLD_BIT       7
`define EOC_MODE_MSB      6
`define EOC_MODE_LSB      4
`define EOC_RSVD_BIT      3
`define EOC_BIAS_MSB      2
`define EOC_BIAS_LSB      0

`define EOC_MODE_OFF0     3'h0
`define EOC_MODE_OFF1     3'h1
`define EOC_MODE_CMOS     3'h2
`define EOC_MODE_CMOS_D2  3'h3
`define EOC_MODE_RC       3'h4
`define EOC_MODE_CAP      3'h5
`define EOC_MODE_XTAL     3'h6
`define EOC_MODE_XTAL_D2  3'h7

`define EOC_SRC_EXT       3'h1

`endif

// ===== rtl/eoc_pkg.sv
// types of the external oscillator control block
package eoc_pkg;

   typedef struct packed {
      logic [2:0] mode;
      logic [2:0] bias;
      logic       stb_meta;
      logic       stb_sync;
      logic       clk_meta;
      logic       clk_sync;
      logic       clk_prev;
      logic       half;
      logic       osc_out;
      logic [7:0] rdata;
   } eoc_state_t;

endpackage

// ===== rtl/eoc_ctrl.sv
// external oscillator control register, mode decode and valid flag
`include "eoc_cfg.svh"

module eoc_ctrl (
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   // special-function register port
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   // analog oscillator side
   input  wire logic       osc_stable_i,
   input  wire logic       ext_clk_i,
   output logic            osc_enable_o,
   output logic            cmos_mode_o,
   output logic            rc_mode_o,
   output logic            cap_mode_o,
   output logic            xtal_mode_o,
   output logic            div2_sel_o,
   output logic      [2:0] ext_osc_bias_code_o,
   output logic            ext_clock_valid_flag_o,
   // system clock selection
   input  wire logic [2:0] sysclk_source_select_i,
   output logic            sysclk_ext_sel_o,
   output logic            sysclk_src_o
);

   eoc_pkg::eoc_state_t state_ff;
   eoc_pkg::eoc_state_t nxt_state;

   logic       ctrl_hit;
   logic       is_div2;
   logic       clk_rise;
   logic       valid;
   logic [7:0] ctrl_rd;

   assign ctrl_hit = (sfr_addr_i == `EOC_CTRL_ADDR);
   assign is_div2  = (state_ff.mode == `EOC_MODE_CMOS_D2) ||
                     (state_ff.mode == `EOC_MODE_XTAL_D2);
   assign clk_rise = state_ff.clk_sync & ~state_ff.clk_prev;

   // only RC, capacitor and crystal codes (1xx) report status; CMOS and off give zero
   assign valid = state_ff.mode[2] & state_ff.stb_sync;

   always_comb begin
      ctrl_rd = 8'h00;
      ctrl_rd[`EOC_VLD_BIT] = valid;
      ctrl_rd[`EOC_MODE_MSB:`EOC_MODE_LSB] = state_ff.mode;
      ctrl_rd[`EOC_BIAS_MSB:`EOC_BIAS_LSB] = state_ff.bias;
   end

   always_comb begin
      nxt_state = state_ff;
      // status and clock pins pass two flops first
      nxt_state.stb_meta = osc_stable_i;
      nxt_state.stb_sync = state_ff.stb_meta;
      nxt_state.clk_meta = ext_clk_i;
      nxt_state.clk_sync = state_ff.clk_meta;
      nxt_state.clk_prev = state_ff.clk_sync;
      // valid bit and reserved bit are not stored
      if (sfr_wr_i && ctrl_hit) begin
         nxt_state.mode = sfr_wdata_i[`EOC_MODE_MSB:`EOC_MODE_LSB];
         nxt_state.bias = sfr_wdata_i[`EOC_BIAS_MSB:`EOC_BIAS_LSB];
      end
      // halving stage toggles on each rising input edge in the two halving modes, held at zero in all others
      if (!is_div2) begin
         nxt_state.half = 1'b0;
      end else if (clk_rise) begin
         nxt_state.half = ~state_ff.half;
      end
      case (state_ff.mode)
         `EOC_MODE_CMOS,
         `EOC_MODE_RC,
         `EOC_MODE_CAP,
         `EOC_MODE_XTAL: begin
            nxt_state.osc_out = state_ff.clk_sync;
         end
         `EOC_MODE_CMOS_D2,
         `EOC_MODE_XTAL_D2: begin
            nxt_state.osc_out = state_ff.half;
         end
         default: begin
            nxt_state.osc_out = 1'b0;
         end
      endcase
      nxt_state.rdata = (sfr_rd_i && ctrl_hit) ? ctrl_rd : 8'h00;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // outputs
   assign sfr_rdata_o            = state_ff.rdata;
   assign osc_enable_o           = |state_ff.mode[2:1];
   assign cmos_mode_o            = (state_ff.mode[2:1] == 2'b01);
   assign rc_mode_o              = (state_ff.mode == `EOC_MODE_RC);
   assign cap_mode_o             = (state_ff.mode == `EOC_MODE_CAP);
   assign xtal_mode_o            = (state_ff.mode[2:1] == 2'b11);
   assign div2_sel_o             = is_div2;
   assign ext_osc_bias_code_o    = state_ff.bias;
   assign ext_clock_valid_flag_o = valid;
   assign sysclk_ext_sel_o       = (sysclk_source_select_i == `EOC_SRC_EXT);
   assign sysclk_src_o           = sysclk_ext_sel_o & state_ff.osc_out;

   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_valid_off: assert property (state_ff.mode[2:1] == 2'b00 |-> !valid)
      else $error("valid flag set while oscillator disabled");
   chk_valid_track: assert property (
      (state_ff.mode[2] && $stable(state_ff.mode) && $past(state_ff.mode[2], 2))
      |-> valid == $past(osc_stable_i, 2))
      else $error("valid flag does not follow oscillator status");
   chk_valid_cmos: assert property (cmos_mode_o |-> !ext_clock_valid_flag_o)
      else $error("valid flag set in CMOS clock mode");
   chk_mode_write: assert property (
      (sfr_wr_i && ctrl_hit) |=> state_ff.mode == $past(sfr_wdata_i[6:4]))
      else $error("mode field not taken from write");
   chk_half_toggle: assert property (
      (is_div2 && clk_rise && $stable(state_ff.mode) && !(sfr_wr_i && ctrl_hit))
      |=> state_ff.half != $past(state_ff.half))
      else $error("halving stage missed an input edge");
   chk_xtal_half_out: assert property (
      (state_ff.mode == `EOC_MODE_XTAL_D2 && $past(is_div2))
      |-> state_ff.osc_out == $past(state_ff.half))
      else $error("halved crystal clock not forwarded");
   chk_rsvd_zero: assert property ((sfr_rd_i && ctrl_hit) |=> !sfr_rdata_o[3])
      else $error("reserved bit read as one");
   chk_bias_fwd: assert property (
      (sfr_wr_i && ctrl_hit) |=> ext_osc_bias_code_o == $past(sfr_wdata_i[2:0]))
      else $error("bias code not forwarded unchanged");
   chk_sysclk_ext: assert property (
      sysclk_source_select_i == 3'h1 |-> sysclk_src_o == state_ff.osc_out)
      else $error("external oscillator not routed as system clock source");
   chk_valid_read: assert property (
      (sfr_rd_i && ctrl_hit && !(sfr_wr_i && ctrl_hit))
      |=> sfr_rdata_o[7] == $past(valid))
      else $error("read valid flag differs from status");
   chk_reset_clear: assert property (
      @(posedge core_clk_i) disable iff (1'b0)
      sys_rst_i |=> (state_ff.mode == 3'h0 && state_ff.bias == 3'h0))
      else $error("reset left the register non-zero");

   // disabled modes and decode
   chk_off_decode: assert property (
      (state_ff.mode[2:1] == 2'b00)
      |-> !osc_enable_o && !cmos_mode_o && !rc_mode_o && !cap_mode_o && !xtal_mode_o)
      else $error("disabled mode drives an oscillator mode output");
   chk_off_out_low: assert property (
      (state_ff.mode[2:1] == 2'b00) |=> !state_ff.osc_out)
      else $error("oscillator output active while disabled");
   chk_rc_cap_decode: assert property (
      (state_ff.mode[2:1] == 2'b10) |-> (rc_mode_o == !state_ff.mode[0]) && (cap_mode_o == state_ff.mode[0]) && !xtal_mode_o)
      else $error("RC or capacitor mode decoded wrongly");

   // clock routing and halving
   chk_cmos_direct: assert property (
      (state_ff.mode == `EOC_MODE_CMOS) |=> state_ff.osc_out == $past(state_ff.clk_sync))
      else $error("CMOS clock not passed through directly");
   chk_cmos_decode: assert property (
      cmos_mode_o |-> osc_enable_o && !xtal_mode_o && (div2_sel_o == state_ff.mode[0]))
      else $error("CMOS mode decode inconsistent");
   chk_half_clear: assert property (!is_div2 |=> !state_ff.half)
      else $error("halving stage not cleared outside halving modes");
   chk_half_hold: assert property (
      (is_div2 && !clk_rise) |=> state_ff.half == $past(state_ff.half))
      else $error("halving stage toggled without an input edge");
   chk_div2_decode: assert property (
      div2_sel_o |-> osc_enable_o && state_ff.mode[1] && state_ff.mode[0])
      else $error("halving selected outside a halving mode");
   chk_xtal_direct: assert property (
      (state_ff.mode == `EOC_MODE_XTAL) |=> state_ff.osc_out == $past(state_ff.clk_sync))
      else $error("crystal clock not passed through directly");
   chk_xtal_decode: assert property (
      xtal_mode_o |-> osc_enable_o && !cmos_mode_o && (div2_sel_o == state_ff.mode[0]))
      else $error("crystal mode decode inconsistent");
   chk_sysclk_other: assert property (
      (sysclk_source_select_i != `EOC_SRC_EXT) |-> !sysclk_src_o && !sysclk_ext_sel_o)
      else $error("external oscillator routed while not selected");

   // register and read path
   chk_bias_hold: assert property (
      !(sfr_wr_i && ctrl_hit) |=> $stable(ext_osc_bias_code_o))
      else $error("bias code changed without a write");
   chk_mode_hold: assert property (
      !(sfr_wr_i && ctrl_hit) |=> $stable(state_ff.mode))
      else $error("mode field changed without a write");
   chk_read_fields: assert property (
      (sfr_rd_i && ctrl_hit) |=> sfr_rdata_o[`EOC_MODE_MSB:`EOC_BIAS_LSB] ==
         {$past(state_ff.mode), 1'b0, $past(state_ff.bias)})
      else $error("read data differs from register fields");
   chk_rdata_idle: assert property (
      !(sfr_rd_i && ctrl_hit) |=> sfr_rdata_o == 8'h00)
      else $error("read data not cleared outside a read");
   chk_valid_unused: assert property (
      !state_ff.stb_sync |-> !ext_clock_valid_flag_o)
      else $error("valid flag set before oscillator stable");

   cov_xtal_valid: cover property (xtal_mode_o && valid);
   cov_cmos_half:  cover property (state_ff.mode == `EOC_MODE_CMOS_D2 && clk_rise);
   cov_ext_read:   cover property (sfr_rd_i && ctrl_hit && valid);
   cov_ext_sysclk: cover property (sysclk_ext_sel_o && sysclk_src_o);
   cov_rd_wr_same: cover property (sfr_rd_i && sfr_wr_i && ctrl_hit);

endmodule

// ===== sim/eoc_osc_model.sv
// behavioural external oscillator: clock and stable flag
module eoc_osc_model (
   input  wire logic core_clk_i,
   input  wire logic en_i,
   output logic      clk_o    = 1'b0,
   output logic      stable_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned run_cnt = 0;
   // stands low while unused, period of eight core cycles once running
   always @(posedge core_clk_i) begin
      run_cnt  <= en_i ? run_cnt + 1 : 0;
      stable_o <= en_i && run_cnt >= 10;
      clk_o    <= en_i ? run_cnt[2] : 1'b0;
   end
endmodule

// ===== sim/tb.sv
// self-checking bench of the external oscillator control
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 0, rst = 1, wr = 0, rd = 0, rd_seen = 0, stb, xclk, sel_ext, src, en;
   logic       cm, rcm, cpm, xm, d2, vld, p;
   logic [7:0] addr = 0, wd = 0, rdat;
   logic [2:0] sel = 0, bias, m, b;
   logic [7:0] exp_q[$];
   int         fail_count = 0, num_checks = 0, cyc = 0, tr;
   always #2.5 clk = ~clk;
   eoc_ctrl dut (.core_clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
      .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat), .osc_stable_i(stb),
      .ext_clk_i(xclk), .osc_enable_o(en), .cmos_mode_o(cm), .rc_mode_o(rcm),
      .cap_mode_o(cpm), .xtal_mode_o(xm), .div2_sel_o(d2), .ext_osc_bias_code_o(bias),
      .ext_clock_valid_flag_o(vld), .sysclk_source_select_i(sel),
      .sysclk_ext_sel_o(sel_ext), .sysclk_src_o(src));
   eoc_osc_model osc (.core_clk_i(clk), .en_i(en), .clk_o(xclk), .stable_o(stb));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [7:0] a, input logic w, input logic r, input logic [7:0] d);
      addr = a;
      wr = w;
      rd = r;
      wd = d;
      @(negedge clk);
      wr = 0;
      rd = 0;
      @(negedge clk);
   endtask
   task automatic complete_run();
      if (exp_q.size() != 0)
         fail_count++;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk) if (rd_seen) check(rdat, exp_q.pop_front());
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(6761));
      repeat (12) @(negedge clk);
      rst = 0;
      exp_q.push_back(8'h00);
      acc(8'hb1, 0, 1, 8'h00);
      for (int i = 0; i < 8; i++) begin
         m = i[2:0];
         b = 3'($urandom);
         acc(8'hb1, 1, 0, {1'b1, m, 1'b0, b});
         sel = 3'h1;
         repeat (20) @(negedge clk);
         tr = 0;
         repeat (32) begin
            p = src;
            @(negedge clk);
            tr += (src !== p);
         end
         check(tr[7:0], (m[2:1] == 0) ? 8'h00 : (m[1:0] == 3) ? 8'h04 : 8'h08);
         check({cm, rcm, cpm, xm, d2, en, 2'b00}, {m[2:1] == 1, m == 4, m == 5,
            m[2:1] == 3, m[1:0] == 3, m[2:1] != 0, 2'b00});
         check({5'h00, bias}, {5'h00, b});
         check({7'h00, vld}, {7'h00, m[2]});
         exp_q.push_back({m[2], m, 1'b0, b});
         acc(8'hb1, 0, 1, 8'h00);
         sel = 3'($urandom);
         @(negedge clk);
         check({6'h00, sel_ext, src & ~sel_ext}, {6'h00, sel == 3'h1, 1'b0});
      end
      acc(8'hb0, 1, 0, 8'h00);
      exp_q.push_back({4'hf, 1'b0, b});
      acc(8'hb1, 1, 1, 8'h00);
      exp_q.push_back(8'h00);
      acc(8'hb2, 0, 1, 8'h00);
      acc(8'hb1, 1, 0, 8'h60);
      exp_q.push_back(8'h60);
      acc(8'hb1, 0, 1, 8'h00);
      rst = 1;
      repeat (3) @(negedge clk);
      rst = 0;
      exp_q.push_back(8'h00);
      acc(8'hb1, 0, 1, 8'h00);
      complete_run();
   end
endmodule
